// *** sspl_top.sv ***
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sspl_top
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        mem_read_n,
	input  wire logic [3:0]  mem_byte_write_n,
	input  wire logic        mem_is_sdram,
	input  wire logic [6:0]  wan_status,
	input  wire logic        ext_wait_n,
	output logic             mem_wait,
	input  wire logic        oe_pin_in,
	output logic             ext_read_output_enable_n,
	output logic             oe_pin_oe,
	input  wire logic [3:0]  we_pin_in,
	output logic [3:0]       ext_byte_write_enable_n,
	output logic [3:0]       we_pin_oe,
	input  wire logic [1:0]  led_pin_in,
	output logic             wan_led_first,
	output logic             wan_led_second,
	output logic [1:0]       led_pin_oe,
	output logic             wdog_reset_polarity_strap,
	output logic [1:0]       boot_bank_width_strap,
	output logic [1:0]       boot_bank_width,
	output logic             boot_width_reserved
);
	// ==========================================
	// Pin synchronisers
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [1:0] wait_s1;
	always_ff @(posedge aclk)
	begin
		sync1 <= {led_pin_in, oe_pin_in};
		sync2 <= sync1;
		wait_s1 <= {wait_s1[0], ext_wait_n};
	end
	assign mem_wait = ~wait_s1[1];

	// ==========================================
	// Pin direction and strap capture
	sspl_pkg::sspl_pin_e pin_st;
	sspl_pkg::sspl_pin_e next_pin_st;
	logic       wdog_pol;
	logic       next_wdog_pol;
	logic [1:0] width;
	logic [1:0] next_width;
	always_comb
	begin
		next_pin_st = pin_st;
		next_wdog_pol = wdog_pol;
		next_width = width;
		unique case (pin_st)
			sspl_pkg::PIN_STRAP:
				next_pin_st = sspl_pkg::PIN_LATCH;
			sspl_pkg::PIN_LATCH:
			begin
				next_wdog_pol = sync2[0];
				next_width = sync2[2:1];
				next_pin_st = sspl_pkg::PIN_DRIVE;
			end
			sspl_pkg::PIN_DRIVE:
				next_pin_st = sspl_pkg::PIN_DRIVE;
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_st <= sspl_pkg::PIN_STRAP;
			wdog_pol <= 1'b0;
			width <= sspl_pkg::WIDTH_RSVD;
		end
		else
		begin
			pin_st <= next_pin_st;
			wdog_pol <= next_wdog_pol;
			width <= next_width;
		end
	end
	logic drive;
	assign drive = (pin_st == sspl_pkg::PIN_DRIVE);
	assign wdog_reset_polarity_strap = wdog_pol;
	assign boot_bank_width_strap = width;
	assign boot_bank_width = width;
	assign boot_width_reserved = drive && (width == sspl_pkg::WIDTH_RSVD);

	// ==========================================
	// Register file
	logic [31:0] wan_misc;
	logic [31:0] next_wan_misc;
	logic [31:0] stb_ctrl;
	logic [31:0] next_stb_ctrl;
	logic        aw_held;
	logic        next_aw_held;
	logic        w_held;
	logic        next_w_held;
	logic [7:0]  aw_addr;
	logic [7:0]  next_aw_addr;
	logic [31:0] w_data;
	logic [31:0] next_w_data;
	logic [3:0]  w_strb;
	logic [3:0]  next_w_strb;
	logic        bvalid;
	logic        next_bvalid;
	logic [1:0]  bresp;
	logic [1:0]  next_bresp;
	logic        rvalid;
	logic        next_rvalid;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic [1:0]  rresp;
	logic [1:0]  next_rresp;
	logic [31:0] strap_stat;
	logic [31:0] wmask;
	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready = !w_held && !bvalid;
	assign s_axi_arready = !rvalid;
	always_comb
	begin
		strap_stat = 32'h0000_0000;
		strap_stat[sspl_pkg::ST_WDOG_BIT] = wdog_pol;
		strap_stat[sspl_pkg::ST_WIDTH_LSB +: 2] = width;
		wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}},
			{8{w_strb[0]}}};
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_wan_misc = wan_misc;
		next_stb_ctrl = stb_ctrl;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (aw_held && w_held)
		begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = sspl_pkg::AXI_OKAY;
			unique case ({aw_addr[7:2], 2'b00})
				sspl_pkg::WAN_MISC_OFFSET:
					next_wan_misc = ((wan_misc & ~wmask) | (w_data & wmask))
						& sspl_pkg::WAN_MISC_MASK;
				sspl_pkg::STROBE_CTRL_OFFSET:
					next_stb_ctrl = ((stb_ctrl & ~wmask) | (w_data & wmask))
						& sspl_pkg::STROBE_CTRL_MASK;
				// Status is read-only, writes ignored
				sspl_pkg::STRAP_STAT_OFFSET:
					next_bresp = sspl_pkg::AXI_OKAY;
				default:
					next_bresp = sspl_pkg::AXI_SLVERR;
			endcase
		end
		if (bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			next_rresp = sspl_pkg::AXI_OKAY;
			unique case ({s_axi_araddr[7:2], 2'b00})
				sspl_pkg::WAN_MISC_OFFSET:    next_rdata = wan_misc;
				sspl_pkg::STRAP_STAT_OFFSET:  next_rdata = strap_stat;
				sspl_pkg::STROBE_CTRL_OFFSET: next_rdata = stb_ctrl;
				default:
				begin
					next_rdata = 32'h0000_0000;
					next_rresp = sspl_pkg::AXI_SLVERR;
				end
			endcase
		end
		else if (rvalid && s_axi_rready)
			next_rvalid = 1'b0;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= sspl_pkg::AXI_OKAY;
			wan_misc <= sspl_pkg::WAN_MISC_RESET;
			stb_ctrl <= sspl_pkg::STROBE_CTRL_RESET;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= sspl_pkg::AXI_OKAY;
		end
		else
		begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			wan_misc <= next_wan_misc;
			stb_ctrl <= next_stb_ctrl;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;

	// ==========================================
	// Strobe and LED output registers
	logic       led_a;
	logic       led_b;
	logic       sdram;
	logic       next_oe_n;
	logic [3:0] next_we_n;
	logic       next_led_first;
	logic       next_led_second;
	logic       oe_n_q;
	logic [3:0] we_n_q;
	logic       led_first_q;
	logic       led_second_q;
	sspl_led_sel u_led_first
	(
		.sel    (wan_misc[sspl_pkg::LED_FIRST_LSB +: 3]),
		.status (wan_status),
		.led    (led_a)
	);
	sspl_led_sel u_led_second
	(
		.sel    (wan_misc[sspl_pkg::LED_SECOND_LSB +: 3]),
		.status (wan_status),
		.led    (led_b)
	);
	// Register bits OR'd in let software force strobes for bring-up
	assign sdram = mem_is_sdram | stb_ctrl[sspl_pkg::STB_SDRAM_BIT];
	always_comb
	begin
		next_oe_n = mem_read_n & ~stb_ctrl[sspl_pkg::STB_OE_BIT];
		next_we_n = (mem_byte_write_n & ~stb_ctrl[sspl_pkg::STB_WE_LSB +: 4])
			| {4{sdram}};
		next_led_first = led_a;
		next_led_second = led_b;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			oe_n_q <= 1'b1;
			we_n_q <= 4'hf;
			led_first_q <= 1'b0;
			led_second_q <= 1'b0;
		end
		else
		begin
			oe_n_q <= next_oe_n;
			we_n_q <= next_we_n;
			led_first_q <= next_led_first;
			led_second_q <= next_led_second;
		end
	end
	assign oe_pin_oe = drive;
	assign we_pin_oe = {4{drive}};
	assign led_pin_oe = {2{drive}};
	assign ext_read_output_enable_n = oe_n_q;
	assign ext_byte_write_enable_n = we_n_q;
	assign wan_led_first = led_first_q;
	assign wan_led_second = led_second_q;
endmodule
`default_nettype wire

// *** sspl_pkg.sv ***
`default_nettype none
package sspl_pkg;
	// Register byte offsets
	localparam logic [7:0] WAN_MISC_OFFSET = 8'h00;
	localparam logic [7:0] STRAP_STAT_OFFSET = 8'h04;
	localparam logic [7:0] STROBE_CTRL_OFFSET = 8'h08;
	// WAN misc control fields
	localparam int LED_FIRST_LSB = 0;
	localparam int LED_SECOND_LSB = 4;
	localparam logic [31:0] WAN_MISC_RESET = 32'h0000_0000;
	localparam logic [31:0] WAN_MISC_MASK = 32'h0000_0077;
	// Strobe control fields
	localparam int STB_OE_BIT = 0;
	localparam int STB_SDRAM_BIT = 1;
	localparam int STB_WE_LSB = 4;
	localparam logic [31:0] STROBE_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] STROBE_CTRL_MASK = 32'h0000_00f3;
	// Strap status fields
	localparam int ST_WDOG_BIT = 0;
	localparam int ST_WIDTH_LSB = 4;
	// LED source codes
	localparam logic [2:0] LED_SPEED = 3'h0;
	localparam logic [2:0] LED_LINK = 3'h1;
	localparam logic [2:0] LED_DUPLEX = 3'h2;
	localparam logic [2:0] LED_COLL = 3'h3;
	localparam logic [2:0] LED_ACT = 3'h4;
	localparam logic [2:0] LED_FDX_COLL = 3'h5;
	localparam logic [2:0] LED_LINK_ACT = 3'h6;
	// Boot bank width codes
	localparam logic [1:0] WIDTH_RSVD = 2'h0;
	localparam logic [1:0] WIDTH_BYTE = 2'h1;
	localparam logic [1:0] WIDTH_HALF = 2'h2;
	localparam logic [1:0] WIDTH_WORD = 2'h3;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	typedef enum logic [2:0]
	{
		PIN_STRAP = 3'b001,
		PIN_LATCH = 3'b010,
		PIN_DRIVE = 3'b100
	} sspl_pin_e;
endpackage
`default_nettype wire

// *** sspl_led_sel.sv ***
`timescale 1ns/1ps
`default_nettype none
module sspl_led_sel
(
	input  wire logic [2:0] sel,
	input  wire logic [6:0] status,
	output logic            led
);
	always_comb
	begin
		unique case (sel)
			sspl_pkg::LED_SPEED:    led = status[0];
			sspl_pkg::LED_LINK:     led = status[1];
			sspl_pkg::LED_DUPLEX:   led = status[2];
			sspl_pkg::LED_COLL:     led = status[3];
			sspl_pkg::LED_ACT:      led = status[4];
			sspl_pkg::LED_FDX_COLL: led = status[5];
			sspl_pkg::LED_LINK_ACT: led = status[6];
			// Code 111 undefined, LED stays dark
			default:                led = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// *** sspl_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module sspl_props
(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       mem_read_n,
	input wire logic       mem_is_sdram,
	input wire logic       oe_pin_in,
	input wire logic       ext_read_output_enable_n,
	input wire logic       oe_pin_oe,
	input wire logic [3:0] we_pin_oe,
	input wire logic [3:0] ext_byte_write_enable_n,
	input wire logic [1:0] led_pin_in,
	input wire logic [1:0] led_pin_oe,
	input wire logic       wdog_reset_polarity_strap,
	input wire logic [1:0] boot_bank_width_strap
);
	// ==========
	// Cycles since release, saturating
	logic [1:0] cnt;
	logic [1:0] next_cnt;
	logic       any_oe;
	logic       all_oe;
	always_comb
	begin
		next_cnt = aresetn ? cnt + 2'(cnt != 2'h3) : 2'h0;
		any_oe = oe_pin_oe | (|led_pin_oe) | (|we_pin_oe);
		all_oe = oe_pin_oe & (&led_pin_oe) & (&we_pin_oe);
	end
	always_ff @(posedge aclk)
	begin
		cnt <= next_cnt;
	end
	// ==========
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_read_req; cnt == 2'h3 && !mem_read_n; endsequence
	// Reset itself is the cause here, so no disable
	property p_rst_pins; disable iff (1'b0) !aresetn |=> !any_oe; endproperty
	a_rst_pins: assert property (p_rst_pins) else $error("pin driven");
	property p_latch; cnt < 2'h2 |-> !any_oe; endproperty
	a_latch: assert property (p_latch) else $error("drive too early");
	property p_drive; cnt[1] |-> all_oe; endproperty
	a_drive: assert property (p_drive) else $error("pin not driven");
	property p_wdog;
		cnt == 2'h2 |-> wdog_reset_polarity_strap == $past(oe_pin_in, 3);
	endproperty
	a_wdog: assert property (p_wdog) else $error("polarity strap");
	property p_width;
		cnt == 2'h2 |-> boot_bank_width_strap == $past(led_pin_in, 3);
	endproperty
	a_width: assert property (p_width) else $error("width strap");
	property p_hold;
		cnt == 2'h3 |-> $stable(wdog_reset_polarity_strap)
			&& $stable(boot_bank_width_strap);
	endproperty
	a_hold: assert property (p_hold) else $error("strap moved");
	property p_read; s_read_req |=> !ext_read_output_enable_n; endproperty
	a_read: assert property (p_read) else $error("read strobe");
	property p_sdram;
		cnt == 2'h3 && mem_is_sdram |=> ext_byte_write_enable_n == 4'hf;
	endproperty
	a_sdram: assert property (p_sdram) else $error("sdram write");
endmodule
bind sspl_top sspl_props u_props (.*);
`default_nettype wire

// *** sspl_ext_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
module sspl_ext_dev
(
	input wire logic       wdog_strap,
	input wire logic [1:0] width_strap,
	input wire logic       slow,
	input wire logic       oe_pin_oe,
	input wire logic       ext_read_output_enable_n,
	input wire logic [3:0] we_pin_oe,
	input wire logic [3:0] ext_byte_write_enable_n,
	input wire logic [1:0] led_pin_oe,
	input wire logic       wan_led_first,
	input wire logic       wan_led_second,
	output logic           oe_pin_in,
	output logic [3:0]     we_pin_in,
	output logic [1:0]     led_pin_in,
	output logic           ext_wait_n
);
	// ==========
	// Board pins
	// Strap resistors set the level while the chip floats
	assign oe_pin_in = oe_pin_oe ? ext_read_output_enable_n : wdog_strap;
	assign led_pin_in = (led_pin_oe & {wan_led_second, wan_led_first})
		| (~led_pin_oe & width_strap);
	assign we_pin_in = ~we_pin_oe | ext_byte_write_enable_n;
	assign ext_wait_n = ~(slow & ~ext_read_output_enable_n);
endmodule
`default_nettype wire

// *** strap_and_strobe_pin_logic_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module strap_and_strobe_pin_logic_bench;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready, mem_read_n, slow;
	logic        mem_is_sdram, ext_wait_n, mem_wait, oe_pin_in, oe_pin_oe;
	logic        ext_read_output_enable_n, wan_led_first, wan_led_second;
	logic        wdog_reset_polarity_strap, boot_width_reserved, wdog_strap;
	logic [1:0]  s_axi_bresp, s_axi_rresp, led_pin_in, led_pin_oe, r;
	logic [1:0]  boot_bank_width_strap, boot_bank_width, width_strap;
	logic [3:0]  s_axi_wstrb, mem_byte_write_n, we_pin_in, we_pin_oe;
	logic [3:0]  ext_byte_write_enable_n;
	logic [6:0]  wan_status;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, v;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	int          miscompares, samples_checked, k, j;
	sspl_top u_dut (.*);
	sspl_ext_dev u_dev (.*);
	// ==========
	// Helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			miscompares++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic stop_test();
		$display("checked %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic step();
		@(posedge aclk);
		@(negedge aclk);
	endtask
	task automatic rst(input int n);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (n) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		step();
	endtask
	// One transfer at a time; waits only on the answer
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] w);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, w};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
		{s_axi_arvalid, s_axi_rready} <= {2{!wr}};
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (wr ? !s_axi_bvalid : !s_axi_rvalid);
		{d, r} = wr ? {32'h0, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
		{s_axi_bready, s_axi_rready} <= 2'h0;
	endtask
	function automatic logic led_exp(input logic [2:0] c);
		return (c == 3'h7) ? 1'b0 : wan_status[c];
	endfunction
	// ==========
	// Clock and watchdog
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	initial
	begin
		#50us;
		miscompares++;
		stop_test();
	end
	// ==========
	// Tests
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
		{s_axi_rready, mem_is_sdram, slow, aresetn} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{mem_read_n, mem_byte_write_n, s_axi_wstrb} = 9'h1ff;
		{wan_status, wdog_strap, width_strap} = 10'h0;
		{miscompares, samples_checked} = 64'h0;
		k = $urandom(32'h8de9);
		for (k = 0; k < 8; k++)
		begin
			{width_strap, wdog_strap} <= 3'(k);
			rst(k == 0 ? 1 : 3);
			chk(32'(wdog_reset_polarity_strap), 32'(k[0]));
			chk(32'(boot_bank_width_strap), 32'(k[2:1]));
			chk(32'(boot_bank_width), 32'(k[2:1]));
			chk(32'(boot_width_reserved), 32'(k < 2));
			axi(1'b0, sspl_pkg::STRAP_STAT_OFFSET, 32'h0);
			chk(d, 32'(k[2:1]) * 16 + 32'(k[0]));
		end
		// Read-only status and an unmapped place
		axi(1'b1, sspl_pkg::STRAP_STAT_OFFSET, 32'hffff_ffff);
		chk(32'(r), 32'(sspl_pkg::AXI_OKAY));
		axi(1'b0, sspl_pkg::STRAP_STAT_OFFSET, 32'h0);
		chk(d, 32'h31);
		axi(1'b1, 8'h40, 32'h1);
		chk(32'(r), 32'(sspl_pkg::AXI_SLVERR));
		axi(1'b0, 8'h40, 32'h0);
		chk(d, 32'h0);
		chk(32'(r), 32'(sspl_pkg::AXI_SLVERR));
		for (k = 0; k < 8; k++)
		begin
			d = $urandom;
			d[6:4] = 3'(7 - k);
			d[2:0] = k[2:0];
			v = d[7:0] & 8'h77;
			axi(1'b1, sspl_pkg::WAN_MISC_OFFSET, d);
			axi(1'b0, sspl_pkg::WAN_MISC_OFFSET, 32'h0);
			chk(d, 32'(v));
			for (j = 0; j < 3; j++)
			begin
				@(posedge aclk);
				wan_status <= 7'($urandom);
				step();
				chk(32'(wan_led_first), 32'(led_exp(v[2:0])));
				chk(32'(wan_led_second), 32'(led_exp(v[6:4])));
			end
		end
		for (k = 0; k < 4; k++)
		begin
			d = $urandom;
			v = d[7:0] & 8'hf3;
			axi(1'b1, sspl_pkg::STROBE_CTRL_OFFSET, d);
			axi(1'b0, sspl_pkg::STROBE_CTRL_OFFSET, 32'h0);
			chk(d, 32'(v));
			step();
			chk(32'(ext_read_output_enable_n), 32'(!v[0]));
			chk(32'(ext_byte_write_enable_n),
				32'(v[1] ? 4'hf : v[7:4] ^ 4'hf));
		end
		axi(1'b1, sspl_pkg::STROBE_CTRL_OFFSET, 32'h0);
		j = 0;
		for (k = 0; k < 40; k++)
		begin
			@(posedge aclk);
			v = 8'($urandom);
			{slow, mem_byte_write_n, mem_read_n} <= {v[7], v[4:0]};
			mem_is_sdram <= v[5] & v[6];
			step();
			chk(32'(ext_read_output_enable_n), 32'(v[0]));
			chk(32'(ext_byte_write_enable_n),
				32'(v[5] & v[6] ? 4'hf : v[4:1]));
			// Wait seen two edges after the pin level
			chk(32'(mem_wait), 32'(j));
			j = int'(v[7] & ~v[0]);
		end
		stop_test();
	end
endmodule
`default_nettype wire
